// ===== logic/dcs_regs.svh
`ifndef DCS_REGS_SVH
`define DCS_REGS_SVH

// Clock period of clk_sys in ns (40 MHz).
`define DCS_CLK_PERIOD_NS 32'h0000_0019
// One step of the auto restart delay is 0.1 s, given here in ns.
`define DCS_DELAY_UNIT_NS 32'h05F5_E100
// Cycles per delay step, derived from the step time and the clock rate.
`define DCS_DELAY_UNIT_CYCLES (`DCS_DELAY_UNIT_NS / `DCS_CLK_PERIOD_NS)
// Percent scale used for all threshold products.
`define DCS_PCT_SCALE 7'h64
// Undervoltage warning level: 85 percent of the supply range top level.
`define DCS_UV_WARN_PCT 7'h55
// Chopper starts at 115 percent and reaches full duty at 120 percent.
`define DCS_CHOP_START_PCT 7'h73
`define DCS_CHOP_FULL_PCT 7'h78
// Chopper PWM carrier: 64 steps per period, counter width 6 bits.
`define DCS_PWM_STEPS 7'h40
`define DCS_PWM_BITS 6
// Reset values of the status flags and of the internal counters.
`define DCS_FLAG_RST 1'h0
`define DCS_COUNT_RST 16'h0000
`define DCS_TICK_RST 32'h0000_0000
`define DCS_PWM_RST 6'h00

`endif

// ===== logic/dcs_pkg.sv
package dcs_pkg;
    // DC link voltage in whole volts.
    typedef logic [11:0] dcs_volt_t;
    // Auto restart delay in steps of 0.1 s; zero means auto restart is off.
    typedef logic [15:0] dcs_delay_t;
endpackage : dcs_pkg

// ===== logic/dcs_tmr_if.sv
`timescale 1ns/10ps
`default_nettype none
interface dcs_tmr_if;
    logic below;
    dcs_pkg::dcs_delay_t delay;
    logic tick;
    logic expired;
    modport owner (output below, output delay, output tick, input expired);
    modport timer (input below, input delay, input tick, output expired);
endinterface : dcs_tmr_if
`default_nettype wire

// ===== logic/dcs_persist.sv
`timescale 1ns/10ps
`default_nettype none
`include "dcs_regs.svh"
module dcs_persist (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Condition and delay
    dcs_tmr_if.timer tmr
);
    import dcs_pkg::*;

    dcs_delay_t count_q;
    dcs_delay_t count_d;
    wire logic count_full = (count_q >= tmr.delay);

    // Any break in the condition restarts the wait, so only a continuous stretch counts.
    assign count_d = !tmr.below ? `DCS_COUNT_RST :
                     (tmr.tick && !count_full) ? count_q + 16'h0001 : count_q;
    assign tmr.expired = tmr.below && count_full;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count_q <= `DCS_COUNT_RST;
        end else begin
            count_q <= count_d;
        end
    end

    AST_COUNT_CLEARS: assert property (@(posedge clk_sys) disable iff (rst)
        !tmr.below |=> count_q == `DCS_COUNT_RST)
        else $error("persistence count not cleared after the condition dropped");
endmodule : dcs_persist
`default_nettype wire

// ===== logic/dcs_supervisor.sv
// How it works
// [R1] Not modulating: warning whenever voltage is below the warning threshold.
// [R2] Modulating, restart delay non-zero: warning when voltage is below standby threshold.
// [R3] That warning holds while continuously below standby, until the delay expires.
// [R4] Modulating, zero delay: trip as soon as voltage is below trip threshold.
// [R5] Modulating, non-zero delay: trip only after continuous low for the delay, less up to one step.
// [R6] Chopper starts switching at 1.15 times the supply range top level.
// [R7] Chopper duty reaches 100 percent at 1.2 times the top level.
// [R8] Chopper stays off whenever overvoltage control is enabled.
// [R9] Warning threshold is 85 percent of the supply range top level.
// [R10] Duty rises linearly between start and full; off below start.
// [R11] Warning and trip are separate flags; trip holds until a reset request.
`timescale 1ns/10ps
`default_nettype none
`include "dcs_regs.svh"
module dcs_supervisor #(
    parameter int unsigned DELAY_UNIT_CYCLES = `DCS_DELAY_UNIT_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Measurement and drive state
    input wire dcs_pkg::dcs_volt_t dc_voltage,
    input wire logic modulating,
    // Configuration
    input wire dcs_pkg::dcs_volt_t supply_range_top_dc_level,
    input wire dcs_pkg::dcs_volt_t standby_level,
    input wire dcs_pkg::dcs_volt_t uv_trip_level,
    input wire dcs_pkg::dcs_delay_t restart_delay,
    input wire logic ovc_enable,
    input wire logic trip_clear,
    // Status and chopper drive
    output logic uv_warning,
    output logic uv_trip,
    output logic chopper_on
);
    import dcs_pkg::*;

    // Delay step timer: free running, so the first step of a wait may be short.
    logic [31:0] tick_cnt_q;
    logic [31:0] tick_cnt_d;
    logic tick_q;
    logic tick_d;
    // Chopper carrier: one full sweep every 64 clocks.
    logic [`DCS_PWM_BITS-1:0] pwm_q;
    logic [`DCS_PWM_BITS-1:0] pwm_d;
    // Status flops behind the three outputs.
    logic warn_q;
    logic warn_d;
    logic trip_q;
    logic trip_d;
    logic chop_q;
    logic chop_d;

    // Two persistence timers share the step pulse and the restart delay.
    dcs_tmr_if standby_tmr ();
    dcs_tmr_if trip_tmr ();

    wire logic delay_on = (restart_delay != 16'h0000);
    wire logic below_standby = (dc_voltage < standby_level);
    wire logic below_trip = (dc_voltage < uv_trip_level);

    // Thresholds are compared as products, so no divider sits in the compare path.
    // [R9] Warning threshold scaling.
    wire logic [19:0] dc_x100 = 20'(dc_voltage) * 20'(`DCS_PCT_SCALE);
    wire logic [19:0] warn_lvl = 20'(supply_range_top_dc_level) * 20'(`DCS_UV_WARN_PCT);
    wire logic below_warn = (dc_x100 < warn_lvl);

    // [R6] [R7] Fixed ends of the chopper band, used by the checks below.
    wire logic [19:0] chop_start_lvl = 20'(supply_range_top_dc_level) * 20'(`DCS_CHOP_START_PCT);
    wire logic [19:0] chop_full_lvl = 20'(supply_range_top_dc_level) * 20'(`DCS_CHOP_FULL_PCT);
    wire logic below_chop_start = (dc_x100 < chop_start_lvl);
    wire logic at_chop_full = (dc_x100 >= chop_full_lvl);

    // The carrier compare avoids a divider: the threshold sweeps 115 to 120 percent per period.
    wire logic [12:0] sweep_pct = 13'(`DCS_CHOP_START_PCT) * 13'(`DCS_PWM_STEPS)
        + 13'(`DCS_CHOP_FULL_PCT - `DCS_CHOP_START_PCT) * 13'(pwm_q);
    wire logic [25:0] dc_scaled = 26'(dc_x100) * 26'(`DCS_PWM_STEPS);
    wire logic [25:0] chop_lvl = 26'(supply_range_top_dc_level) * 26'(sweep_pct);

    // A wait only runs while the drive modulates; when idle, both counts stay at zero.
    assign standby_tmr.below = modulating && below_standby;
    assign standby_tmr.delay = restart_delay;
    assign standby_tmr.tick = tick_q;
    assign trip_tmr.below = modulating && below_trip;
    assign trip_tmr.delay = restart_delay;
    assign trip_tmr.tick = tick_q;

    dcs_persist u_standby_wait (
        .clk_sys(clk_sys),
        .rst(rst),
        .tmr(standby_tmr.timer)
    );

    dcs_persist u_trip_wait (
        .clk_sys(clk_sys),
        .rst(rst),
        .tmr(trip_tmr.timer)
    );

    // [R1] [R2] [R3] Warning conditions.
    // The idle term uses the fixed 85 percent level, the modulating term the standby input.
    // Modulating with zero delay has no warning term, because the trip follows at once.
    assign warn_d = (!modulating && below_warn)
        || (modulating && delay_on && below_standby && !standby_tmr.expired);

    // [R4] [R5] [R11] Sticky trip; a new trip event wins over a clear.
    // A clear held high cannot hide a trip that is still present.
    wire logic trip_set = modulating && below_trip && (!delay_on || trip_tmr.expired);
    assign trip_d = trip_set || (trip_q && !trip_clear);

    // [R6] [R7] [R8] [R10] Chopper compare against the sweeping threshold.
    // Above the band the compare holds for every carrier step, so the duty is full.
    assign chop_d = !ovc_enable && (dc_scaled >= chop_lvl);

    // [R5] Delay step pulse, one clock wide.
    // The step timer never stops, so a wait may end up to one step early; this was
    // preferred to one timer per condition, which would cost one more wide counter.
    assign tick_d = (tick_cnt_q == DELAY_UNIT_CYCLES - 1);
    assign tick_cnt_d = tick_d ? `DCS_TICK_RST : tick_cnt_q + 32'h0000_0001;
    assign pwm_d = pwm_q + 6'h01;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tick_cnt_q <= `DCS_TICK_RST;
            tick_q <= `DCS_FLAG_RST;
        end else begin
            tick_cnt_q <= tick_cnt_d;
            tick_q <= tick_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pwm_q <= `DCS_PWM_RST;
        end else begin
            pwm_q <= pwm_d;
        end
    end

    // [R11] Warning, trip and chopper flags kept apart.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            warn_q <= `DCS_FLAG_RST;
            trip_q <= `DCS_FLAG_RST;
            chop_q <= `DCS_FLAG_RST;
        end else begin
            warn_q <= warn_d;
            trip_q <= trip_d;
            chop_q <= chop_d;
        end
    end

    // Outputs are plain copies of flops, so no decode glitch reaches the pins.
    assign uv_warning = warn_q;
    assign uv_trip = trip_q;
    assign chopper_on = chop_q;

    // Undervoltage checks. Each one looks one clock after the inputs that cause it.

    AST_WARN_IDLE: assert property (@(posedge clk_sys) disable iff (rst) // [R1]
        (!modulating && below_warn) |=> uv_warning)
        else $error("warning missing while idle and below warning level");

    AST_WARN_LEVEL: assert property (@(posedge clk_sys) disable iff (rst) // [R9]
        (!modulating && !below_warn) |=> !uv_warning)
        else $error("warning shown while idle at or above warning level");

    AST_WARN_STANDBY: assert property (@(posedge clk_sys) disable iff (rst) // [R2]
        (modulating && delay_on && below_standby && !standby_tmr.expired) |=> uv_warning)
        else $error("warning missing while modulating below standby level");

    AST_WARN_ZERO: assert property (@(posedge clk_sys) disable iff (rst) // [R2]
        (modulating && !delay_on) |=> !uv_warning)
        else $error("warning shown while modulating with zero restart delay");

    AST_WARN_ENDS: assert property (@(posedge clk_sys) disable iff (rst) // [R3]
        (modulating && standby_tmr.expired) |=> !uv_warning)
        else $error("warning still shown after the restart delay expired");

    AST_TRIP_FAST: assert property (@(posedge clk_sys) disable iff (rst) // [R4]
        (modulating && !delay_on && below_trip) |=> uv_trip)
        else $error("trip not raised at once with zero restart delay");

    AST_TRIP_WAITS: assert property (@(posedge clk_sys) disable iff (rst) // [R5]
        (!uv_trip && modulating && delay_on && below_trip && !trip_tmr.expired) |=> !uv_trip)
        else $error("trip raised before the restart delay elapsed");

    AST_TRIP_SET: assert property (@(posedge clk_sys) disable iff (rst) // [R5]
        (modulating && delay_on && below_trip && trip_tmr.expired) |=> uv_trip)
        else $error("trip not raised when the restart delay elapsed");

    AST_TICK_PULSE: assert property (@(posedge clk_sys) disable iff (rst) // [R5]
        tick_q |=> !tick_q)
        else $error("delay step pulse longer than one clock");

    AST_TRIP_HOLD: assert property (@(posedge clk_sys) disable iff (rst) // [R11]
        (uv_trip && !trip_clear) |=> uv_trip)
        else $error("trip dropped without a reset request");

    AST_TRIP_CLEAR: assert property (@(posedge clk_sys) disable iff (rst) // [R11]
        (uv_trip && trip_clear && !trip_set) |=> !uv_trip)
        else $error("trip not cleared by reset request");

    // Chopper checks. The band runs from 115 to 120 percent of the top level.

    AST_CHOP_LOW: assert property (@(posedge clk_sys) disable iff (rst) // [R6]
        below_chop_start |=> !chopper_on)
        else $error("chopper on below start level");

    AST_CHOP_START: assert property (@(posedge clk_sys) disable iff (rst) // [R6]
        (!ovc_enable && !below_chop_start && pwm_q == `DCS_PWM_RST) |=> chopper_on)
        else $error("chopper not switching at start level");

    AST_CHOP_FULL: assert property (@(posedge clk_sys) disable iff (rst) // [R7]
        (!ovc_enable && at_chop_full) |=> chopper_on)
        else $error("chopper not at full duty at full level");

    AST_CHOP_OVC: assert property (@(posedge clk_sys) disable iff (rst) // [R8]
        ovc_enable |=> !chopper_on)
        else $error("chopper active with overvoltage control enabled");
endmodule : dcs_supervisor
`default_nettype wire

// ===== verif/dcs_link_model.sv
`timescale 1ns/10ps
`default_nettype none
module dcs_link_model (
    // Clock and bench control
    input wire logic clk_sys,
    input wire dcs_pkg::dcs_volt_t level,
    input wire logic cnt_clear,
    // Block side
    output var dcs_pkg::dcs_volt_t dc_voltage,
    input wire logic chopper_on,
    output logic [7:0] on_cnt
);
    import dcs_pkg::*;
    // The measurement is sampled, so the block sees a new level one edge late.
    always_ff @(posedge clk_sys) begin
        dc_voltage <= level;
        on_cnt <= cnt_clear ? 8'h00 : on_cnt + {7'h00, chopper_on};
    end
endmodule : dcs_link_model
`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import dcs_pkg::*;
    logic clk_sys = 1'h0;
    logic rst = 1'h1;
    dcs_volt_t level = 12'h3E8;
    dcs_volt_t dc_voltage;
    logic modulating = 1'h0;
    logic ovc_enable = 1'h0;
    logic trip_clear = 1'h0;
    logic cnt_clear = 1'h0;
    dcs_delay_t restart_delay = 16'h0000;
    logic uv_warning, uv_trip, chopper_on;
    logic [7:0] on_cnt;
    int err_total = 0;
    int total_checks = 0;
    int n;
    dcs_supervisor #(.DELAY_UNIT_CYCLES(10)) DUT (.clk_sys(clk_sys), .rst(rst),
        .dc_voltage(dc_voltage), .modulating(modulating),
        .supply_range_top_dc_level(12'h3E8), .standby_level(12'h2BC),
        .uv_trip_level(12'h258), .restart_delay(restart_delay), .ovc_enable(ovc_enable),
        .trip_clear(trip_clear), .uv_warning(uv_warning), .uv_trip(uv_trip),
        .chopper_on(chopper_on));
    dcs_link_model link (.clk_sys(clk_sys), .level(level), .cnt_clear(cnt_clear),
        .dc_voltage(dc_voltage), .chopper_on(chopper_on), .on_cnt(on_cnt));
    initial forever #12.5 clk_sys = ~clk_sys;
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : complete_run
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic sc_warn_idle;
        @(posedge clk_sys);
        level <= 12'h352;
        tick(3);
        check("warn at 850", uv_warning, 1'h0);
        @(posedge clk_sys);
        level <= 12'h351;
        tick(3);
        check("warn at 849", uv_warning, 1'h1);
    endtask : sc_warn_idle
    task automatic sc_trip_now;
        @(posedge clk_sys);
        modulating <= 1'h1;
        level <= 12'h257;
        trip_clear <= 1'h1;
        tick(3);
        check("trip zero delay", uv_trip, 1'h1);
        check("warn zero delay", uv_warning, 1'h0);
        @(posedge clk_sys);
        level <= 12'h3E8;
        tick(4);
        check("trip cleared", uv_trip, 1'h0);
        @(posedge clk_sys);
        trip_clear <= 1'h0;
    endtask : sc_trip_now
    task automatic sc_trip_delayed;
        @(posedge clk_sys);
        restart_delay <= 16'h0002;
        level <= 12'h257;
        tick(3);
        check("warn standby", uv_warning, 1'h1);
        check("trip early", uv_trip, 1'h0);
        n = 3;
        while (uv_trip !== 1'h1 && n < 40) begin
            tick(1);
            n++;
            if (n == 9) check("warn held", uv_warning, 1'h1);
        end
        check("trip delay window", 16'(n >= 11 && n <= 25), 16'h0001);
        tick(3);
        check("warn after expiry", uv_warning, 1'h0);
        check("trip sticky", uv_trip, 1'h1);
        @(posedge clk_sys);
        level <= 12'h3E8;
        tick(3);
        check("trip held high dc", uv_trip, 1'h1);
        if (n >= 40) complete_run();
    endtask : sc_trip_delayed
    task automatic sc_reset_mid;
        @(posedge clk_sys);
        rst <= 1'h1;
        @(posedge clk_sys);
        @(posedge clk_sys);
        rst <= 1'h0;
        tick(1);
        check("trip after reset", uv_trip, 1'h0);
        check("warn after reset", uv_warning, 1'h0);
    endtask : sc_reset_mid
    task automatic duty(input logic [11:0] v, input logic ovc, input logic [7:0] exp);
        @(posedge clk_sys);
        level <= v;
        ovc_enable <= ovc;
        tick(3);
        @(posedge clk_sys);
        cnt_clear <= 1'h1;
        @(posedge clk_sys);
        cnt_clear <= 1'h0;
        tick(64);
        check("chopper on cycles", {8'h00, on_cnt}, {8'h00, exp});
    endtask : duty
    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'h0;
        sc_warn_idle();
        sc_trip_now();
        sc_trip_delayed();
        sc_reset_mid();
        duty(12'h47D, 1'h0, 8'h00);
        duty(12'h47E, 1'h0, 8'h01);
        duty(12'h497, 1'h0, 8'h21);
        duty(12'h4B0, 1'h0, 8'h40);
        duty(12'h4B0, 1'h1, 8'h00);
        complete_run();
    end
endmodule : testbench
`default_nettype wire
